// ### logic/clk_ctrl_map.svh
// Constants for the clock prescaler and power-mode gating block
`ifndef CLK_CTRL_MAP_SVH
`define CLK_CTRL_MAP_SVH

// ***************************************************
// Prescaler geometry
// ***************************************************
`define SYS_PRE_W     13
`define SYS_PRE_RST   13'h0000
`define SUB_PRE_W     5
`define SUB_PRE_RST   5'h00

// ***************************************************
// System clock divider ahead of the system prescaler
// ***************************************************
`define DIV_CNT_W     6
`define DIV_CNT_RST   6'h00
`define DIV_SEL_W     3
`define DIV_SEL_MAX   3'h6

// ***************************************************
// Subclock sampling and phase counter
// ***************************************************
`define SYNC_STAGES   3
`define SYNC_RST      3'h0
`define PH_W          3
`define PH_RST        3'h0
`define PH_QUARTER    2'h3
`define SUBDIV_SEL_W  2
`define SUBDIV_2      2'h0
`define SUBDIV_4      2'h1
`define SUBDIV_8      2'h2

// ***************************************************
// Clock rates
// ***************************************************
`define SYS_CLK_HZ    40000000
`define SUB_CLK_HZ    32768

`endif

// ### logic/clk_ctrl_pkg.sv
// Types for the clock prescaler and power-mode gating block
package clk_ctrl_pkg;
`include "clk_ctrl_map.svh"

   // Operating modes after reset
   typedef enum logic [2:0] {
      MODE_ACTIVE,
      MODE_SLEEP,
      MODE_SUBACTIVE,
      MODE_SUBSLEEP,
      MODE_STANDBY
   } power_mode_t;

   // Whole state of the block in one word
   typedef struct packed {
      power_mode_t                    mode;
      logic [`DIV_CNT_W-1:0]          div_cnt;
      logic [`SYS_PRE_W-1:0]          pres_s;
      logic [`SYNC_STAGES-1:0]        sync;
      logic                           sub_lvl;
      logic [`PH_W-1:0]               ph;
      logic [`SUB_PRE_W-1:0]          pres_w;
   } clk_state_t;

endpackage : clk_ctrl_pkg

// ### logic/tap_pulse_gen.sv
// Turns a binary prescaler count into one-cycle divided enable pulses
module tap_pulse_gen #(
   parameter int WIDTH = 13
) (
   input  wire logic [WIDTH-1:0] i_count,
   input  wire logic             i_advance,
   output wire logic [WIDTH-1:0] o_tap
);

   // ***************************************************
   // Elaboration check
   // ***************************************************
   if (WIDTH < 1) begin : g_bad_width
      $error("tap_pulse_gen needs WIDTH of at least one");
   end

   // ***************************************************
   // Tap decode
   // ***************************************************
   // Tap i fires when bits i..0 are all ones and the count steps,
   // which is once per 2^(i+1) steps; no derived clock is made
   for (genvar i = 0; i < WIDTH; i++) begin : g_tap
      assign o_tap[i] = i_advance & (&i_count[i:0]);
   end

endmodule : tap_pulse_gen

// ### logic/clock_prescalers_mode_gating.sv
// Clock prescalers and per-mode clock gating for the CPU and peripherals
// Functional notes
// - System prescaler is 13-bit up-counter, one step per divided system clock tick.
// - Reset clears system prescaler; counting starts at reset release.
// - Standby, subactive, subsleep: system prescaler stopped and held at zero.
// - System prescaler has no processor read or write path.
// - Shared taps from divided system clock over 2 to over 8192, chosen per peripheral.
// - In active and sleep, prescaler input is system clock over selected divisor.
// - Subclock prescaler is 5-bit counter fed by subclock over four.
// - Subclock taps over 8 to over 128 feed the timer timebase.
// - Reset clears subclock prescaler; counting starts at reset release.
// - Subclock prescaler keeps counting in standby, subactive and subsleep.
// - Active: processor and peripherals clocked from divided system clock.
// - Subactive: processor and peripherals on subclock over two, four or eight.
// - Sleep: processor stopped, peripherals keep system clock.
// - Subsleep: processor stopped, peripherals keep subclock.
// - Standby: all halted except timebase real-time clock when selected.
// - Each unused peripheral can be halted alone by gating its clock.
// - Software standby select: zero enters sleep or subsleep, one standby.
`include "clk_ctrl_map.svh"

module clock_prescalers_mode_gating #(
   parameter int N_PERIPH = 8
) (
   input  wire logic                       i_clk,
   input  wire logic                       i_rst,
   input  wire logic                       i_sub_clk,
   input  wire logic [`DIV_SEL_W-1:0]      i_sys_clk_div_select,
   input  wire logic [`SUBDIV_SEL_W-1:0]   i_sub_div_select,
   input  wire logic                       i_software_standby_select,
   input  wire logic                       i_sleep_exec,
   input  wire logic                       i_sub_transfer,
   input  wire logic                       i_wake,
   input  wire logic                       i_wake_to_sub,
   input  wire logic                       i_timebase_select,
   input  wire logic [N_PERIPH-1:0]        i_module_standby,
   output clk_ctrl_pkg::power_mode_t       o_mode,
   output wire logic [`SYS_PRE_W-1:0]      o_sys_taps,
   output wire logic [`SUB_PRE_W-1:0]      o_sub_taps,
   output wire logic                       o_cpu_ce,
   output wire logic [N_PERIPH-1:0]        o_periph_ce,
   output wire logic                       o_rtc_ce,
   output wire logic                       o_sys_running
);
   import clk_ctrl_pkg::*;

   // ***************************************************
   // Elaboration checks
   // ***************************************************
   if (N_PERIPH < 1) begin : g_bad_periph
      $error("N_PERIPH must be at least one");
   end
   // The sampler needs several system ticks per subclock half period
   if (`SYS_CLK_HZ < 8 * `SUB_CLK_HZ) begin : g_bad_rate
      $error("System clock too slow to sample the subclock");
   end

   // ***************************************************
   // Decode functions
   // ***************************************************
   // Divisor 2^sel for the system prescaler input, codes above six read as six
   function automatic logic [`DIV_CNT_W-1:0] sys_div_mask(
      input logic [`DIV_SEL_W-1:0] sel
   );
      logic [`DIV_SEL_W-1:0] s;
      s = (sel > `DIV_SEL_MAX) ? `DIV_SEL_MAX : sel;
      sys_div_mask = `DIV_CNT_W'((7'h01 << s) - 7'h01);
   endfunction : sys_div_mask

   // Phase mask for subclock over two, four or eight; spare code gives eight
   function automatic logic [`PH_W-1:0] sub_div_mask(
      input logic [`SUBDIV_SEL_W-1:0] sel
   );
      case (sel)
         `SUBDIV_2: sub_div_mask = 3'h1;
         `SUBDIV_4: sub_div_mask = 3'h3;
         `SUBDIV_8: sub_div_mask = 3'h7;
         default:   sub_div_mask = 3'h7;
      endcase
   endfunction : sub_div_mask

   // ***************************************************
   // State and decoded strobes
   // ***************************************************
   clk_state_t             state_q;
   clk_state_t             state_d;
   logic                   sys_run;
   logic                   sys_ce;
   logic                   sub_agree;
   logic                   sub_edge;
   logic                   w_adv;
   logic                   sub_ce;
   logic                   periph_base;
   logic                   cpu_ce;
   logic [`SYS_PRE_W-1:0]  sys_taps;
   logic [`SUB_PRE_W-1:0]  sub_taps;

   // Strobes shared by the next-state logic and the gating
   always_comb begin
      sys_run   = (state_q.mode == MODE_ACTIVE) || (state_q.mode == MODE_SLEEP);
      sys_ce    = sys_run &&
                  ((state_q.div_cnt & sys_div_mask(i_sys_clk_div_select)) ==
                   sys_div_mask(i_sys_clk_div_select));
      // Only the second and third stages are looked at, never the first
      sub_agree = (state_q.sync[1] == state_q.sync[2]);
      sub_edge  = sub_agree && state_q.sync[2] && !state_q.sub_lvl;
      w_adv     = sub_edge && (state_q.ph[1:0] == `PH_QUARTER);
      sub_ce    = sub_edge &&
                  ((state_q.ph & sub_div_mask(i_sub_div_select)) ==
                   sub_div_mask(i_sub_div_select));
   end

   // ***************************************************
   // Next state
   // ***************************************************
   // One pass builds the whole next state from the current one
   always_comb begin
      state_d = state_q;

      // Three-stage pin sampler, level accepted when stages two and three agree
      state_d.sync = {state_q.sync[`SYNC_STAGES-2:0], i_sub_clk};
      if (sub_agree) begin
         state_d.sub_lvl = state_q.sync[2];
      end

      // Subclock phase counter runs whatever the mode
      if (sub_edge) begin
         state_d.ph = state_q.ph + `PH_W'(1);
      end

      // Subclock prescaler keeps stepping in every mode
      if (w_adv) begin
         state_d.pres_w = state_q.pres_w + `SUB_PRE_W'(1);
      end

      // System divider and prescaler stop and clear with the system clock
      if (sys_run) begin
         state_d.div_cnt = state_q.div_cnt + `DIV_CNT_W'(1);
         if (sys_ce) begin
            state_d.pres_s = state_q.pres_s + `SYS_PRE_W'(1);
         end
      end else begin
         state_d.div_cnt = `DIV_CNT_RST;
         state_d.pres_s  = `SYS_PRE_RST;
      end

      // Mode sequencing on the sleep instruction, transfers and wake-ups
      case (state_q.mode)
         MODE_ACTIVE: begin
            if (i_sleep_exec) begin
               state_d.mode = i_software_standby_select ? MODE_STANDBY
                                                        : MODE_SLEEP;
            end else if (i_sub_transfer) begin
               state_d.mode = MODE_SUBACTIVE;
            end
         end
         MODE_SLEEP: begin
            if (i_wake) begin
               state_d.mode = MODE_ACTIVE;
            end
         end
         MODE_SUBACTIVE: begin
            if (i_sleep_exec) begin
               state_d.mode = i_software_standby_select ? MODE_STANDBY
                                                        : MODE_SUBSLEEP;
            end else if (i_sub_transfer) begin
               state_d.mode = MODE_ACTIVE;
            end
         end
         MODE_SUBSLEEP: begin
            if (i_wake) begin
               state_d.mode = MODE_SUBACTIVE;
            end
         end
         MODE_STANDBY: begin
            if (i_wake) begin
               state_d.mode = i_wake_to_sub ? MODE_SUBACTIVE : MODE_ACTIVE;
            end
         end
         default: begin
            state_d.mode = MODE_ACTIVE;
         end
      endcase
   end

   // ***************************************************
   // State register
   // ***************************************************
   // Everything clears on reset, so both prescalers start from zero
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   // ***************************************************
   // Divided taps
   // ***************************************************
   // The counter itself never leaves this block; only taps do
   tap_pulse_gen #(
      .WIDTH     (`SYS_PRE_W)
   ) u_sys_taps (
      .i_count   (state_q.pres_s),
      .i_advance (sys_ce),
      .o_tap     (sys_taps)
   );

   tap_pulse_gen #(
      .WIDTH     (`SUB_PRE_W)
   ) u_sub_taps (
      .i_count   (state_q.pres_w),
      .i_advance (w_adv),
      .o_tap     (sub_taps)
   );

   // ***************************************************
   // Mode gating
   // ***************************************************
   // Processor runs only in the two active modes
   always_comb begin
      case (state_q.mode)
         MODE_ACTIVE:    cpu_ce = sys_ce;
         MODE_SUBACTIVE: cpu_ce = sub_ce;
         default:        cpu_ce = 1'b0;
      endcase
   end

   // Peripherals follow the system clock or the subclock, none in standby
   always_comb begin
      case (state_q.mode)
         MODE_ACTIVE,
         MODE_SLEEP:     periph_base = sys_ce;
         MODE_SUBACTIVE,
         MODE_SUBSLEEP:  periph_base = sub_ce;
         default:        periph_base = 1'b0;
      endcase
   end

   // Per-module standby cuts each peripheral enable on its own
   for (genvar i = 0; i < N_PERIPH; i++) begin : g_periph
      assign o_periph_ce[i] = periph_base & ~i_module_standby[i];
   end

   // Timebase tick uses the slowest subclock tap, alive even in standby
   assign o_rtc_ce      = i_timebase_select & sub_taps[`SUB_PRE_W-1];
   assign o_cpu_ce      = cpu_ce;
   assign o_sys_taps    = sys_taps;
   assign o_sub_taps    = sub_taps;
   assign o_mode        = state_q.mode;
   assign o_sys_running = sys_run;

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence sleep_cmd_s;
      state_q.mode == MODE_ACTIVE && i_sleep_exec && !i_software_standby_select;
   endsequence

   sequence standby_cmd_s;
      (state_q.mode == MODE_ACTIVE || state_q.mode == MODE_SUBACTIVE) &&
      i_sleep_exec && i_software_standby_select;
   endsequence

   sequence sub_sleep_cmd_s;
      state_q.mode == MODE_SUBACTIVE && i_sleep_exec && !i_software_standby_select;
   endsequence

   a_pres_s_step: assert property (
      sys_ce |=> state_q.pres_s == $past(state_q.pres_s) + `SYS_PRE_W'(1))
      else $error("System prescaler did not step");

   a_start_from_zero: assert property (
      $past(i_rst) |-> state_q.pres_s == `SYS_PRE_RST && state_q.pres_w == `SUB_PRE_RST)
      else $error("Prescalers not zero after reset");

   a_pres_s_held: assert property (
      !sys_run ##1 !sys_run |-> state_q.pres_s == `SYS_PRE_RST && !sys_ce)
      else $error("System prescaler not held at zero");

   a_div_one_rate: assert property (
      sys_ce && i_sys_clk_div_select == 3'h1 ##1
      i_sys_clk_div_select == 3'h1 && sys_run |-> !sys_ce)
      else $error("Divide-by-two input stepped twice running");

   a_tap_spacing: assert property (
      sys_taps[0] |=> !sys_taps[0])
      else $error("Fastest tap lasted more than one cycle");

   a_pres_w_runs: assert property (
      w_adv |=> state_q.pres_w == $past(state_q.pres_w) + `SUB_PRE_W'(1))
      else $error("Subclock prescaler did not step");

   a_cpu_halted: assert property (
      state_q.mode inside {MODE_SLEEP, MODE_SUBSLEEP, MODE_STANDBY} |-> !o_cpu_ce)
      else $error("Processor enabled in a halt mode");

   a_active_cpu: assert property (
      state_q.mode == MODE_ACTIVE |-> o_cpu_ce == sys_ce)
      else $error("Processor enable not from system clock");

   a_sub_cpu_edge: assert property (
      state_q.mode == MODE_SUBACTIVE && o_cpu_ce |-> sub_edge && state_q.ph[0])
      else $error("Subactive enable off the subclock grid");

   a_sleep_periph: assert property (
      state_q.mode == MODE_SLEEP && sys_ce && !i_module_standby[0] |-> o_periph_ce[0])
      else $error("Peripheral lost system clock in sleep");

   a_module_gate: assert property (
      i_module_standby[0] |-> !o_periph_ce[0])
      else $error("Standby peripheral still enabled");

   a_standby_halt: assert property (
      state_q.mode == MODE_STANDBY |-> o_periph_ce == '0)
      else $error("Peripheral enabled in standby");

   a_sleep_entry: assert property (
      sleep_cmd_s |=> state_q.mode == MODE_SLEEP)
      else $error("Sleep not entered");

   a_standby_entry: assert property (
      standby_cmd_s |=> state_q.mode == MODE_STANDBY)
      else $error("Standby not entered");

   a_subsleep_entry: assert property (
      sub_sleep_cmd_s |=> state_q.mode == MODE_SUBSLEEP)
      else $error("Subsleep not entered");

   a_sub_transfer: assert property (
      state_q.mode == MODE_ACTIVE && i_sub_transfer && !i_sleep_exec |=> state_q.mode == MODE_SUBACTIVE)
      else $error("Subactive not entered on transfer");

   a_subsleep_wake: assert property (
      state_q.mode == MODE_SUBSLEEP && i_wake |=> state_q.mode == MODE_SUBACTIVE)
      else $error("Subsleep wake did not return to subactive");

   a_pres_w_hold: assert property (
      !w_adv |=> $stable(state_q.pres_w))
      else $error("Subclock prescaler moved without a quarter step");

endmodule : clock_prescalers_mode_gating

// ### tb/sub_clock_source.sv
// Subclock oscillator stand-in driving the block's subclock pin
module sub_clock_source #(
   parameter int HALF_NS = 125
) (
   input  wire logic i_run,
   output var  logic o_sub_clk
);
   timeunit 1ns;
   timeprecision 1ps;

   // Runs far faster than a watch crystal so slow taps show up in a short run
   initial begin
      o_sub_clk = 1'b0;
      #7;
      forever begin
         #HALF_NS;
         // With no resonator fitted the pin is tied low
         o_sub_clk = i_run ? ~o_sub_clk : 1'b0;
      end
   end
endmodule : sub_clock_source

// ### tb/clock_prescalers_mode_gating_tb.sv
// Self-checking bench for the clock prescaler and power-mode gating block
module clock_prescalers_mode_gating_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import clk_ctrl_pkg::*;

   localparam int SUB_P = 10;
   localparam int WIN   = 256;

   logic        i_clk, i_rst, sub_run, i_sub_clk;
   logic [2:0]  div_sel;
   logic [1:0]  sub_sel;
   logic        software_standby_select, sleep_exec, sub_transfer, wake, wake_to_sub, timebase;
   logic [7:0]  mstby;
   power_mode_t o_mode;
   logic [12:0] o_sys_taps;
   logic [4:0]  o_sub_taps;
   logic        o_cpu_ce, o_rtc_ce, o_sys_running;
   logic [7:0]  o_periph_ce;
   power_mode_t m_mode;
   int          m_cnt, m_div, n_fail, checks_done, c_cpu, c_per, c_rtc;
   int          c_tap [5];
   logic [2:0]  m_sync;
   logic        m_lvl;
   int          m_ph, m_w;

   // ****************************************
   // Clock, partner and design
   // ****************************************
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   sub_clock_source #(.HALF_NS(SUB_P * 25 / 2)) u_sub (.i_run(sub_run), .o_sub_clk(i_sub_clk));

   clock_prescalers_mode_gating #(.N_PERIPH(8)) u_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_sub_clk(i_sub_clk),
      .i_sys_clk_div_select(div_sel), .i_sub_div_select(sub_sel),
      .i_software_standby_select(software_standby_select), .i_sleep_exec(sleep_exec),
      .i_sub_transfer(sub_transfer), .i_wake(wake), .i_wake_to_sub(wake_to_sub),
      .i_timebase_select(timebase), .i_module_standby(mstby), .o_mode(o_mode),
      .o_sys_taps(o_sys_taps), .o_sub_taps(o_sub_taps), .o_cpu_ce(o_cpu_ce),
      .o_periph_ce(o_periph_ce), .o_rtc_ce(o_rtc_ce), .o_sys_running(o_sys_running));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic bit sys_mode(power_mode_t m);
      return m == MODE_ACTIVE || m == MODE_SLEEP;
   endfunction : sys_mode

   // Subclock edge in the model: stages two and three agree high while the level was low
   function automatic bit m_sedge();
      return m_sync[1] == m_sync[2] && m_sync[2] && !m_lvl;
   endfunction : m_sedge

   // Divider enable of the model; code 7 behaves as 6
   function automatic bit m_ce();
      int s;
      s = (div_sel == 3'h7) ? 6 : int'(div_sel);
      return sys_mode(m_mode) && ((m_div & ((1 << s) - 1)) == ((1 << s) - 1));
   endfunction : m_ce

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   // Subclock counts may slip by one against the window edges
   task automatic near(input int got, input int exp);
      checks_done++;
      if (got < exp - 1 || got > exp + 1) begin
         n_fail++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : near

   task automatic pulse(input int k);
      @(posedge i_clk);
      sleep_exec <= (k == 0);
      sub_transfer <= (k == 1);
      wake <= (k == 2);
      @(posedge i_clk);
      sleep_exec <= 1'b0;
      sub_transfer <= 1'b0;
      wake <= 1'b0;
   endtask : pulse

   task automatic do_reset();
      @(posedge i_clk);
      i_rst <= 1'b1;
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
   endtask : do_reset

   task automatic win();
      @(posedge i_clk);
      c_tap = '{default: 0};
      c_cpu = 0;
      c_per = 0;
      c_rtc = 0;
      repeat (WIN * SUB_P) @(posedge i_clk);
   endtask : win

   task automatic sub_checks(input int cpu_exp, input int per_exp);
      for (int i = 0; i < 5; i++) near(c_tap[i], (WIN / 8) >> i);
      near(c_cpu, cpu_exp);
      near(c_per, per_exp);
   endtask : sub_checks

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   // ****************************************
   // Reference model and per-cycle compare
   // ****************************************
   // Standby, subactive and subsleep clear the count at their first edge
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         m_mode <= MODE_ACTIVE;
         m_cnt <= 0;
         m_div <= 0;
         m_sync <= 3'h0;
         m_lvl <= 1'b0;
         m_ph <= 0;
         m_w <= 0;
      end else begin
         m_cnt <= sys_mode(m_mode) ? ((m_cnt + int'(m_ce())) & 32'h1FFF) : 0;
         m_div <= sys_mode(m_mode) ? ((m_div + 1) & 32'h3F) : 0;
         // Subclock side runs in every mode: three-stage sampler, phase, quarter-rate count
         m_sync <= {m_sync[1:0], i_sub_clk};
         if (m_sync[1] == m_sync[2]) m_lvl <= m_sync[2];
         if (m_sedge()) m_ph <= (m_ph + 1) & 32'h7;
         if (m_sedge() && (m_ph & 3) == 3) m_w <= (m_w + 1) & 32'h1F;
         if (sleep_exec && m_mode == MODE_ACTIVE) m_mode <= software_standby_select ? MODE_STANDBY : MODE_SLEEP;
         else if (sleep_exec && m_mode == MODE_SUBACTIVE) m_mode <= software_standby_select ? MODE_STANDBY : MODE_SUBSLEEP;
         else if (sub_transfer && m_mode == MODE_ACTIVE) m_mode <= MODE_SUBACTIVE;
         else if (sub_transfer && m_mode == MODE_SUBACTIVE) m_mode <= MODE_ACTIVE;
         else if (wake && m_mode == MODE_SLEEP) m_mode <= MODE_ACTIVE;
         else if (wake && m_mode == MODE_SUBSLEEP) m_mode <= MODE_SUBACTIVE;
         else if (wake && m_mode == MODE_STANDBY) m_mode <= wake_to_sub ? MODE_SUBACTIVE : MODE_ACTIVE;
      end
   end

   // Outputs are settled at the falling edge
   always @(negedge i_clk) begin
      logic [12:0] t;
      logic        ce;
      logic [4:0]  st;
      logic        sce;
      logic        wadv;
      int          msk;
      if (!i_rst) begin
         ce = m_ce();
         // Subclock taps and subclock enables predicted from the model's own counters
         wadv = m_sedge() && ((m_ph & 3) == 3);
         msk = (sub_sel == 2'h0) ? 1 : ((sub_sel == 2'h1) ? 3 : 7);
         sce = m_sedge() && ((m_ph & msk) == msk);
         for (int i = 0; i < 5; i++) st[i] = wadv && ((m_w & ((2 << i) - 1)) == ((2 << i) - 1));
         chk(o_sub_taps, st);
         if (m_mode == MODE_SUBACTIVE) chk(o_cpu_ce, sce);
         if (m_mode inside {MODE_SUBACTIVE, MODE_SUBSLEEP}) chk(o_periph_ce, {8{sce}} & ~mstby);
         for (int i = 0; i < 13; i++) t[i] = ce && ((m_cnt & ((2 << i) - 1)) == ((2 << i) - 1));
         chk(o_mode, m_mode);
         chk(o_sys_running, sys_mode(m_mode));
         chk(o_sys_taps, t);
         if (m_mode == MODE_ACTIVE) chk(o_cpu_ce, ce);
         if (m_mode inside {MODE_SLEEP, MODE_SUBSLEEP, MODE_STANDBY}) chk(o_cpu_ce, 1'b0);
         if (sys_mode(m_mode)) chk(o_periph_ce, {8{ce}} & ~mstby);
         else chk(o_periph_ce & mstby, 8'h00);
         if (m_mode == MODE_STANDBY) chk(o_periph_ce, 8'h00);
         chk(o_rtc_ce, timebase & st[4]);
         for (int i = 0; i < 5; i++) c_tap[i] += int'(o_sub_taps[i]);
         c_cpu += int'(o_cpu_ce);
         c_per += int'(o_periph_ce[0]);
         c_rtc += int'(o_rtc_ce);
      end
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      {i_rst, sub_run} = 2'h3;
      {div_sel, sub_sel, software_standby_select, sleep_exec, sub_transfer, wake, wake_to_sub, timebase} = 11'h000;
      mstby = 8'h00;
      void'($urandom(32'h701bb52e));
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      // Every divisor code; code 0 runs long enough for the slowest tap
      for (int s = 0; s < 8; s++) begin
         div_sel <= 3'(s);
         mstby <= 8'($urandom);
         do_reset();
         repeat ((s == 0) ? 8300 : 600) @(posedge i_clk);
         $display("test divider %0d done", s);
      end
      div_sel <= 3'h1;
      mstby <= 8'($urandom) & 8'hFE;
      timebase <= 1'b1;
      do_reset();
      repeat (200) @(posedge i_clk);
      pulse(0);
      repeat (200) @(posedge i_clk);
      pulse(2);
      repeat (100) @(posedge i_clk);
      pulse(1);
      for (int s = 0; s < 4; s++) begin
         sub_sel <= 2'(s);
         win();
         sub_checks(WIN >> ((s > 2) ? 3 : s + 1), WIN >> ((s > 2) ? 3 : s + 1));
      end
      pulse(0);
      win();
      sub_checks(0, WIN / 8);
      pulse(2);
      software_standby_select <= 1'b1;
      pulse(0);
      win();
      sub_checks(0, 0);
      near(c_rtc, WIN / 128);
      pulse(2);
      repeat (300) @(posedge i_clk);
      pulse(0);
      timebase <= 1'b0;
      wake_to_sub <= 1'b1;
      repeat (200) @(posedge i_clk);
      pulse(2);
      repeat (200) @(posedge i_clk);
      $display("test mode sequence done");
      stop_test();
   end

   // Whole run is about 29000 cycles
   initial begin
      repeat (60000) @(posedge i_clk);
      n_fail++;
      $display("unexpected timeout at %0t: got %0h expected %0h", $time, 0, 1);
      stop_test();
   end
endmodule : clock_prescalers_mode_gating_tb
